// >>> rtl/sid_pkg.sv
// Purpose: Shared constants and types for the ion sensor command and sequencer block
// Assumes: One 10 MHz clock, AXI4-Lite register access, command and timing pins asynchronous
// Notes:   Counter limits are last states, not state counts
package sid_pkg;

	// Command and one-time codes
	localparam logic [3:0]  SEAL_CODE        = 4'h5;
	localparam logic [3:0]  COVER_CODE       = 4'h7;

	// Frame counter
	localparam logic [6:0]  FRAME_LAST       = 7'h7F;
	localparam logic [6:0]  FRAME_AT_TEN     = 7'h0A;
	localparam logic [6:0]  FRAME_AT_39      = 7'h27;
	localparam logic [6:0]  FRAME_AT_79      = 7'h4F;
	localparam logic [6:0]  CAL_FIRST        = 7'h78;

	// Step counters
	localparam logic [4:0]  VEL_LAST         = 5'h13;
	localparam logic [4:0]  VEL_AT_NINE      = 5'h09;
	localparam logic [2:0]  LE_LAST          = 3'h5;
	localparam logic [4:0]  HE_LAST          = 5'h13;
	localparam logic [4:0]  GP_LAST          = 5'h17;
	localparam logic [6:0]  VF_MAX           = 7'h7F;
	localparam logic [3:0]  LONG_DIV_LAST    = 4'h9;

	// Register offsets and reset values
	localparam logic [7:0]  ADDR_STATUS      = 8'h00;
	localparam logic [7:0]  ADDR_COUNTERS    = 8'h04;
	localparam logic [7:0]  ADDR_DECODE_LO   = 8'h08;
	localparam logic [7:0]  ADDR_DECODE_HI   = 8'h0C;
	localparam logic [31:0] RST_DECODE_LO    = 32'h7654_3210;
	localparam logic [31:0] RST_DECODE_HI    = 32'hFEDC_BA98;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	// Truncation modes
	typedef enum logic [1:0] {
		TRUNC_NONE = 2'h0,
		TRUNC_TEN  = 2'h1,
		TRUNC_39   = 2'h3,
		TRUNC_79   = 2'h2
	} sid_trunc_t;

	// Decoded command functions
	typedef enum logic [3:0] {
		FN_NOP         = 4'h0,
		FN_GP_STEP     = 4'h1,
		FN_FRAME_TEN   = 4'h2,
		FN_FRAME_39    = 4'h3,
		FN_VEL_NINE    = 4'h4,
		FN_FRAME_79    = 4'h5,
		FN_COMBINED    = 4'h6,
		FN_LONG_TOGGLE = 4'h7,
		FN_GLOBAL_RST  = 4'h8,
		FN_VF_HV       = 4'h9,
		FN_LE_HV       = 4'hA,
		FN_HE_HV       = 4'hB,
		FN_FORCED_CAL  = 4'hC,
		FN_GAUGE_HV    = 4'hD,
		FN_MULT_HV     = 4'hE,
		FN_INBUF_CLEAR = 4'hF
	} sid_fn_t;

	// Command and timing pins
	typedef struct packed {
		logic [3:0] cmd_code;
		logic       cmd_exec;
		logic       shift;
		logic       data_demand;
		logic       frame_mark;
		logic       even_frame_mark;
		logic       parity;
	} sid_pins_t;

	// On/off enables
	typedef struct packed {
		logic vf_hv;
		logic le_hv;
		logic he_hv;
		logic gauge_hv;
		logic mult_hv;
		logic gp_step;
	} sid_en_t;

	// Stepping supply settings and sequencer pulses
	typedef struct packed {
		logic [6:0] vf_step;
		logic [2:0] le_step;
		logic [4:0] he_step;
		logic [4:0] gp_step;
		logic       cal_gate;
		logic [1:0] cal_select;
		logic       sync_pulse;
		logic       advance_pulse;
	} sid_steps_t;

	// Strobe gate timing towards data handling
	typedef struct packed {
		logic shift;
		logic word;
		logic even_frame;
	} sid_dh_t;

endpackage : sid_pkg

// >>> rtl/sid_sequencer.sv
// Purpose: Command decode, one-time commands and programmer sequencing of the ion sensor
// Assumes: Pins are asynchronous pulses; rising edge marks a pulse
// Notes:   AXI4-Lite slave gives status, counters and the code decode table
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps

// Behaviour
// - Four code lines form the command code
// - Act only on the execute pulse
// - Code pulses into buffer, copied on execute
// - Decode mode buffer, route control action
// - First seal code arms one-time seal break
// - Later seal codes reach input buffer only
// - Cover code fires cover release once
// - Input and mode buffers shown as status
// - Sequencer timing from partner timing pulses
// - Accept command pulses and parity pulse
// - 128-state frame counter is time reference
// - Sync and advance pulses to counters
// - Calibration gates at counting period end
// - Velocity counter 120 steps, 20 each
// - Low energy counter has six steps
// - Frame truncation at 10, 39, 79
// - Velocity truncation at count nine
// - Combined truncation: frame 79, velocity nine
// - Toggle ten-times accumulation interval
// - On/off toggles for each supply enable
// - Command clears the input buffer
// - Ground plane steps on frame wrap, 24 steps
// - High energy counter has 20 steps
// - Calibration zeroes analyzers, velocity maximum
module sid_sequencer (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire sid_pkg::sid_pins_t  pins,
	output logic                     seal_break,
	output logic                     cover_release,
	output sid_pkg::sid_en_t         enables,
	output sid_pkg::sid_steps_t      steps,
	output sid_pkg::sid_dh_t         dh_timing,
	output logic [3:0]               input_buffer,
	output logic [3:0]               mode_buffer,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready
);
	import sid_pkg::*;

	typedef struct packed {
		sid_pins_t  sy1;
		sid_pins_t  sy2;
		sid_pins_t  prev;
		logic [3:0] inbuf;
		logic [3:0] mode;
		logic       exec_pend;
		logic       seal_seen;
		logic       seal_arm;
		logic       cover_seen;
		logic       cover_arm;
		logic       seal_out;
		logic       cover_out;
		sid_en_t    en;
		sid_trunc_t trunc;
		logic       vel_nine;
		logic       long_on;
		logic       forced_cal;
		logic [3:0] long_div;
		logic [6:0] frame;
		logic [4:0] vel;
		logic [2:0] le;
		logic [4:0] he;
		logic [4:0] gp;
		logic       parity_bit;
		sid_steps_t out;
		sid_dh_t    dh;
		logic [31:0] dec_lo;
		logic [31:0] dec_hi;
		logic       aw_ok;
		logic [7:0] awaddr;
		logic       w_ok;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sid_state_t;

	sid_state_t  st_r;
	sid_state_t  st_nxt;
	sid_pins_t   rise;
	sid_fn_t     fn;
	logic [63:0] table_bits;
	logic [6:0]  frame_limit;
	logic [4:0]  vel_limit;
	logic        adv;
	logic        cal;
	logic [31:0] merged;

	assign s_axi_awready = !st_r.aw_ok && !st_r.bvalid;
	assign s_axi_wready  = !st_r.w_ok && !st_r.bvalid;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rdata   = st_r.rdata;
	assign s_axi_rresp   = st_r.rresp;
	assign seal_break    = st_r.seal_out;
	assign cover_release = st_r.cover_out;
	assign enables       = st_r.en;
	assign steps         = st_r.out;
	assign dh_timing     = st_r.dh;
	assign input_buffer  = st_r.inbuf;
	assign mode_buffer   = st_r.mode;

	always_comb begin
		st_nxt = st_r;
		rise = st_r.sy2 & ~st_r.prev;
		table_bits = {st_r.dec_hi, st_r.dec_lo};
		fn = sid_fn_t'(table_bits[{st_r.mode, 2'b00} +: 4]);
		adv = 1'b0;
		merged = 32'h0000_0000;

		// Pins pass two flops before the edge detector
		st_nxt.sy1  = pins;
		st_nxt.sy2  = st_r.sy1;
		st_nxt.prev = st_r.sy2;

		st_nxt.seal_out  = 1'b0;
		st_nxt.cover_out = 1'b0;
		st_nxt.out.sync_pulse    = 1'b0;
		st_nxt.out.advance_pulse = 1'b0;

		// Code pulses accumulate in the input buffer
		st_nxt.inbuf = st_r.inbuf | rise.cmd_code;

		// One-time register catches only the first appearance
		if (!st_r.seal_seen && st_nxt.inbuf == SEAL_CODE) begin
			st_nxt.seal_seen = 1'b1;
			st_nxt.seal_arm  = 1'b1;
		end
		if (!st_r.cover_seen && st_nxt.inbuf == COVER_CODE) begin
			st_nxt.cover_seen = 1'b1;
			st_nxt.cover_arm  = 1'b1;
		end

		// Mode buffer strobed on execute, decoded one cycle later
		st_nxt.exec_pend = rise.cmd_exec;
		if (rise.cmd_exec) begin
			st_nxt.mode = st_r.inbuf;
		end

		if (st_r.exec_pend) begin
			if (st_r.seal_arm) begin
				st_nxt.seal_out = 1'b1;
				st_nxt.seal_arm = 1'b0;
			end
			if (st_r.cover_arm) begin
				st_nxt.cover_out = 1'b1;
				st_nxt.cover_arm = 1'b0;
			end
			case (fn)
				FN_GP_STEP:     st_nxt.en.gp_step = !st_r.en.gp_step;
				FN_FRAME_TEN:   st_nxt.trunc = TRUNC_TEN;
				FN_FRAME_39:    st_nxt.trunc = TRUNC_39;
				FN_FRAME_79:    st_nxt.trunc = TRUNC_79;
				FN_VEL_NINE:    st_nxt.vel_nine = 1'b1;
				FN_COMBINED: begin
					st_nxt.trunc    = TRUNC_79;
					st_nxt.vel_nine = 1'b1;
				end
				FN_LONG_TOGGLE: st_nxt.long_on = !st_r.long_on;
				FN_VF_HV:       st_nxt.en.vf_hv = !st_r.en.vf_hv;
				FN_LE_HV:       st_nxt.en.le_hv = !st_r.en.le_hv;
				FN_HE_HV:       st_nxt.en.he_hv = !st_r.en.he_hv;
				FN_GAUGE_HV:    st_nxt.en.gauge_hv = !st_r.en.gauge_hv;
				FN_MULT_HV:     st_nxt.en.mult_hv = !st_r.en.mult_hv;
				FN_FORCED_CAL:  st_nxt.forced_cal = !st_r.forced_cal;
				// New code pulses in the clearing cycle survive
				FN_INBUF_CLEAR: st_nxt.inbuf = rise.cmd_code;
				default: begin
				end
			endcase
		end

		// Frame advance on frame mark, every tenth when interval is long
		if (rise.frame_mark) begin
			if (st_r.long_on && st_r.long_div != LONG_DIV_LAST) begin
				st_nxt.long_div = st_r.long_div + 4'h1;
			end else begin
				st_nxt.long_div = 4'h0;
				adv = 1'b1;
			end
		end

		case (st_r.trunc)
			TRUNC_TEN: frame_limit = FRAME_AT_TEN;
			TRUNC_39:  frame_limit = FRAME_AT_39;
			TRUNC_79:  frame_limit = FRAME_AT_79;
			default:   frame_limit = FRAME_LAST;
		endcase
		vel_limit = st_r.vel_nine ? VEL_AT_NINE : VEL_LAST;
		cal = st_r.frame >= CAL_FIRST || st_r.forced_cal;

		if (adv) begin
			st_nxt.out.advance_pulse = 1'b1;
			if (st_r.frame >= frame_limit) begin
				st_nxt.frame = 7'h00;
				st_nxt.out.sync_pulse = 1'b1;
				if (st_r.en.gp_step) begin
					st_nxt.gp = (st_r.gp == GP_LAST) ? 5'h00 : st_r.gp + 5'h01;
				end
			end else begin
				st_nxt.frame = st_r.frame + 7'h01;
			end
			// Velocity, low and high energy steps hold still while calibration gates are open
			if (!cal) begin
				st_nxt.he = (st_r.he == HE_LAST) ? 5'h00 : st_r.he + 5'h01;
				if (st_r.vel >= vel_limit) begin
					st_nxt.vel = 5'h00;
					st_nxt.le  = (st_r.le == LE_LAST) ? 3'h0 : st_r.le + 3'h1;
				end else begin
					st_nxt.vel = st_r.vel + 5'h01;
				end
			end
		end

		// Global reset last so it overrides any counter advance; advance and sync pulses still go out
		if (st_r.exec_pend && fn == FN_GLOBAL_RST) begin
			st_nxt.frame      = 7'h00;
			st_nxt.vel        = 5'h00;
			st_nxt.le         = 3'h0;
			st_nxt.he         = 5'h00;
			st_nxt.gp         = 5'h00;
			st_nxt.long_div   = 4'h0;
			st_nxt.trunc      = TRUNC_NONE;
			st_nxt.vel_nine   = 1'b0;
			st_nxt.long_on    = 1'b0;
			st_nxt.forced_cal = 1'b0;
		end

		// Supply settings; calibration blanks ion counts
		st_nxt.out.cal_gate   = st_nxt.frame >= CAL_FIRST || st_nxt.forced_cal;
		st_nxt.out.cal_select = st_nxt.frame[1:0];
		if (st_nxt.out.cal_gate) begin
			st_nxt.out.vf_step = VF_MAX;
			st_nxt.out.le_step = 3'h0;
			st_nxt.out.he_step = 5'h00;
		end else begin
			st_nxt.out.vf_step = {2'b00, st_nxt.vel} + {st_nxt.le, 4'h0} + {2'b00, st_nxt.le, 2'b00};
			st_nxt.out.le_step = st_nxt.le;
			st_nxt.out.he_step = st_nxt.he;
		end
		st_nxt.out.gp_step = st_nxt.gp;

		// Strobe gate timing and frame parity
		st_nxt.dh.shift      = rise.shift;
		st_nxt.dh.word       = rise.data_demand;
		st_nxt.dh.even_frame = rise.even_frame_mark;
		if (rise.parity) begin
			st_nxt.parity_bit = !st_r.parity_bit;
		end

		// Write channel: address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			st_nxt.aw_ok  = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_nxt.w_ok  = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		if (st_r.aw_ok && st_r.w_ok) begin
			st_nxt.aw_ok  = 1'b0;
			st_nxt.w_ok   = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = RESP_OKAY;
			merged = st_r.awaddr[7:2] == ADDR_DECODE_LO[7:2] ? st_r.dec_lo : st_r.dec_hi;
			for (int i = 0; i < 4; i++) begin
				if (st_r.wstrb[i]) begin
					merged[i*8 +: 8] = st_r.wdata[i*8 +: 8];
				end
			end
			case (st_r.awaddr[7:2])
				ADDR_DECODE_LO[7:2]: st_nxt.dec_lo = merged;
				ADDR_DECODE_HI[7:2]: st_nxt.dec_hi = merged;
				ADDR_STATUS[7:2], ADDR_COUNTERS[7:2]: begin
				end
				default: st_nxt.bresp = RESP_SLVERR;
			endcase
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// Read channel: one-cycle answer
		if (s_axi_arvalid && s_axi_arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = RESP_OKAY;
			case (s_axi_araddr[7:2])
				ADDR_STATUS[7:2]: st_nxt.rdata = {8'h00, st_r.parity_bit, st_r.forced_cal, st_r.long_on,
					st_r.vel_nine, st_r.trunc, st_r.cover_seen, st_r.seal_seen, 2'b00, st_r.en,
					st_r.mode, st_r.inbuf};
				ADDR_COUNTERS[7:2]: st_nxt.rdata = {2'b00, st_r.gp, st_r.he, st_r.le, st_r.vel,
					st_r.long_div, 1'b0, st_r.frame};
				ADDR_DECODE_LO[7:2]: st_nxt.rdata = st_r.dec_lo;
				ADDR_DECODE_HI[7:2]: st_nxt.rdata = st_r.dec_hi;
				default: begin
					st_nxt.rdata = 32'h0000_0000;
					st_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end else if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// One-time flags clear only here; they never rearm in flight
			st_r        <= '0;
			st_r.trunc  <= TRUNC_NONE;
			st_r.dec_lo <= RST_DECODE_LO;
			st_r.dec_hi <= RST_DECODE_HI;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule : sid_sequencer

// >>> sim/sid_sequencer_bench.sv
// Purpose: Self-checking bench for the ion sensor command and sequencer
// Assumes: Command lines from the station model, registers over AXI4-Lite
// Notes:   Counters read back through the counter register
`timescale 1ns/1ps
module sid_sequencer_bench;
	import sid_pkg::*;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	sid_pins_t   pins;
	logic        seal_break, cover_release;
	sid_en_t     enables;
	sid_steps_t  steps;
	sid_dh_t     dh_timing;
	logic [3:0]  input_buffer, mode_buffer;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	int          mismatches = 0, num_checks = 0, seal_n = 0, cover_n = 0, sync_n = 0, dh_n = 0, cal_n = 0, s;
	logic [3:0]  en_code [6] = '{4'h9, 4'hA, 4'hB, 4'hD, 4'hE, 4'h1};
	logic [3:0]  tr_code [4] = '{4'h2, 4'h3, 4'h5, 4'h6};
	int          tr_len [4] = '{11, 40, 80, 80};

	always #50 aclk = ~aclk;

	sid_station_model i_st (.aclk(aclk), .pins(pins));

	sid_sequencer i_dut (
		.aclk(aclk), .aresetn(aresetn), .pins(pins), .seal_break(seal_break), .cover_release(cover_release),
		.enables(enables), .steps(steps), .dh_timing(dh_timing), .input_buffer(input_buffer),
		.mode_buffer(mode_buffer), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	always @(posedge aclk) begin
		if (seal_break === 1'b1) seal_n <= seal_n + 1;
		if (cover_release === 1'b1) cover_n <= cover_n + 1;
		if (steps.sync_pulse === 1'b1) sync_n <= sync_n + 1;
		if (steps.cal_gate === 1'b1) cal_n <= cal_n + 1;
		dh_n <= dh_n + $countones(dh_timing);
	end

	task automatic summarize();
		if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= be;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		if (n >= 50) begin
			chk("write wait", 32'h1, 32'h0);
			summarize();
		end
		chk("bresp", bresp, er);
	endtask : axw

	task automatic axr(input logic [7:0] a, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		rd = rdata;
		if (n >= 50) begin
			chk("read wait", 32'h1, 32'h0);
			summarize();
		end
		chk("rresp", rresp, er);
	endtask : axr

	// Code, execute, then clear: the input buffer only ever ORs bits in
	task automatic cmd(input logic [3:0] c);
		i_st.pulse({c, 6'h00});
		i_st.pulse(10'h020);
		repeat (3) @(posedge aclk);
		i_st.pulse(10'h3C0);
		i_st.pulse(10'h020);
		repeat (3) @(posedge aclk);
	endtask : cmd

	initial begin
		// Bus idles driven from here, so every request line has one driver
		awaddr  <= 8'h00;
		araddr  <= 8'h00;
		wdata   <= 32'h0000_0000;
		wstrb   <= 4'h0;
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		bready  <= 1'b0;
		arvalid <= 1'b0;
		rready  <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axr(ADDR_STATUS, RESP_OKAY);
		chk("status", rd, 32'h0);
		axr(ADDR_DECODE_LO, RESP_OKAY);
		chk("decode lo", rd, RST_DECODE_LO);
		axr(8'h10, RESP_SLVERR);
		chk("unmapped read", rd, 32'h0000_0000);
		axw(8'h10, 32'h0000_0000, 4'hF, RESP_SLVERR);
		i_st.pulse({SEAL_CODE, 6'h00});
		repeat (2) @(posedge aclk);
		chk("inbuf", input_buffer, SEAL_CODE);
		i_st.pulse(10'h020);
		repeat (3) @(posedge aclk);
		chk("mode", mode_buffer, SEAL_CODE);
		chk("seal", seal_n, 1);
		cmd(4'hF);
		chk("inbuf clear", input_buffer, 32'h0);
		cmd(SEAL_CODE);
		chk("seal again", seal_n, 1);
		cmd(COVER_CODE);
		cmd(COVER_CODE);
		chk("cover", cover_n, 1);
		for (int i = 0; i < 6; i++) begin
			cmd(en_code[i]);
			chk("enables", enables, (32'h3F << (5 - i)) & 32'h3F);
		end
		axw(ADDR_DECODE_HI, 32'hF0DC_BA98, 4'hF, RESP_OKAY);
		axr(ADDR_DECODE_HI, RESP_OKAY);
		chk("decode hi", rd, 32'hF0DC_BA98);
		// Only byte lane 0 may land; codes 0 and 1 are not used again
		axw(ADDR_DECODE_LO, 32'hFFFF_FF01, 4'h1, RESP_OKAY);
		axr(ADDR_DECODE_LO, RESP_OKAY);
		chk("decode lo strobe", rd, 32'h7654_3201);
		cmd(4'hE);
		chk("remapped", enables, 32'h3F);
		cmd(4'h9);
		chk("vf off", enables, 32'h1F);
		i_st.pulse(10'h001);
		i_st.pulse(10'h010);
		i_st.pulse(10'h008);
		i_st.pulse(10'h002);
		repeat (3) @(posedge aclk);
		chk("strobes", dh_n, 3);
		axr(ADDR_STATUS, RESP_OKAY);
		chk("status", rd, 32'h008B_1FF0);
		i_st.hold = 4;
		cmd(4'h4);
		i_st.marks(10);
		i_st.hold = 2;
		axr(ADDR_COUNTERS, RESP_OKAY);
		chk("vel nine", rd, 32'h00A2_000A);
		cmd(4'h8);
		axr(ADDR_COUNTERS, RESP_OKAY);
		chk("global reset", rd, 32'h0);
		for (int i = 0; i < 4; i++) begin
			cmd(tr_code[i]);
			s = sync_n;
			i_st.marks(tr_len[i]);
			repeat (3) @(posedge aclk);
			chk("trunc sync", sync_n - s, 1);
			axr(ADDR_COUNTERS, RESP_OKAY);
			chk("trunc frame", rd[6:0], 32'h0);
		end
		chk("gp", steps.gp_step, 32'h4);
		cmd(4'h8);
		s = sync_n;
		i_st.marks(128);
		repeat (3) @(posedge aclk);
		chk("full sync", sync_n - s, 1);
		chk("cal seen", 32'(cal_n > 0), 32'h1);
		axr(ADDR_COUNTERS, RESP_OKAY);
		chk("full", rd & 32'h3E00_007F, 32'h0200_0000);
		cmd(COVER_CODE);
		i_st.marks(9);
		axr(ADDR_COUNTERS, RESP_OKAY);
		chk("long 9", rd[6:0], 32'h0);
		i_st.marks(1);
		axr(ADDR_COUNTERS, RESP_OKAY);
		chk("long 10", rd[6:0], 32'h1);
		cmd(4'hC);
		chk("forced cal", steps.cal_gate, 32'h1);
		summarize();
	end
endmodule : sid_sequencer_bench

// >>> sim/sid_sequencer_props.sv
// Purpose: Port assertions for the ion sensor command and sequencer
// Assumes: One clock, synchronous active-low reset
// Notes:   Watches a subset of the top ports only
`timescale 1ns/1ps
module sid_sequencer_props (
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire sid_pkg::sid_pins_t  pins,
	input wire logic                seal_break,
	input wire logic                cover_release,
	input wire sid_pkg::sid_steps_t steps,
	input wire sid_pkg::sid_dh_t    dh_timing,
	input wire logic [3:0]          input_buffer,
	input wire logic [3:0]          mode_buffer
);
	import sid_pkg::*;

	logic [1:0] seal_n_r;
	logic [1:0] cover_n_r;

	// Saturating, so a stuck pulse cannot wrap back to a legal count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seal_n_r  <= 2'h0;
			cover_n_r <= 2'h0;
		end else begin
			if (seal_break && seal_n_r != 2'h3) seal_n_r <= seal_n_r + 2'h1;
			if (cover_release && cover_n_r != 2'h3) cover_n_r <= cover_n_r + 2'h1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence shift_rise;
		$rose(pins.shift);
	endsequence
	sequence strobe_once;
		dh_timing.shift ##1 !dh_timing.shift;
	endsequence

	seal_mode_a: assert property (seal_break |-> mode_buffer == SEAL_CODE)
		else $error("seal break without seal code in mode buffer");
	cover_mode_a: assert property (cover_release |-> mode_buffer == COVER_CODE)
		else $error("cover release without cover code in mode buffer");
	one_time_a: assert property (seal_n_r <= 2'h1 && cover_n_r <= 2'h1)
		else $error("one-time output fired twice");
	mode_copy_a: assert property ($changed(mode_buffer) |-> mode_buffer == $past(input_buffer))
		else $error("mode buffer not a copy of input buffer");
	code_bit_a: assert property ($rose(pins.cmd_code[0]) |-> ##[2:5] input_buffer[0])
		else $error("code line pulse not captured");
	wrap_sync_a: assert property (steps.sync_pulse |-> steps.advance_pulse && steps.cal_select == 2'h0)
		else $error("sync pulse without frame wrap");
	adv_step_a: assert property (steps.advance_pulse && !steps.sync_pulse
		|-> steps.cal_select == $past(steps.cal_select) + 2'h1)
		else $error("frame did not step on advance");
	cal_out_a: assert property (steps.cal_gate
		|-> steps.vf_step == VF_MAX && steps.le_step == 3'h0 && steps.he_step == 5'h00)
		else $error("supply steps wrong during calibration");
	step_range_a: assert property (!steps.cal_gate |-> steps.vf_step < 7'h78 && steps.le_step <= LE_LAST
		&& steps.he_step <= HE_LAST && steps.gp_step <= GP_LAST)
		else $error("step counter out of range");
	gp_move_a: assert property ($changed(steps.gp_step) |-> steps.sync_pulse || steps.gp_step == 5'h00)
		else $error("ground plane stepped off frame wrap");
	strobe_a: assert property (shift_rise |-> ##[3:5] strobe_once)
		else $error("shift strobe missing or too long");
endmodule : sid_sequencer_props

bind sid_sequencer sid_sequencer_props i_props (
	.aclk          (aclk),
	.aresetn       (aresetn),
	.pins          (pins),
	.seal_break    (seal_break),
	.cover_release (cover_release),
	.steps         (steps),
	.dh_timing     (dh_timing),
	.input_buffer  (input_buffer),
	.mode_buffer   (mode_buffer)
);

// >>> sim/sid_station_model.sv
// Purpose: Data subsystem side of the command and timing lines
// Assumes: Lines idle low, each event is a rising edge
// Notes:   Raise hold to answer slowly
`timescale 1ns/1ps
module sid_station_model (
	input  wire logic          aclk,
	output sid_pkg::sid_pins_t pins
);
	import sid_pkg::*;

	int hold = 2;

	initial pins = '0;

	task automatic pulse(input logic [9:0] v);
		@(posedge aclk);
		pins <= sid_pins_t'(v);
		repeat (hold) @(posedge aclk);
		pins <= '0;
		repeat (hold) @(posedge aclk);
	endtask : pulse

	task automatic marks(input int n);
		repeat (n) pulse(10'h004);
	endtask : marks
endmodule : sid_station_model
